// ### common/flash_option_byte_defines.svh
// Purpose: Offsets, field positions, reset values and the fetch address for the option block
// Assumes: Byte-wide registers on a plain register port
// Notes:   Definitions only
`ifndef FLASH_OPTION_BYTE_DEFINES_SVH
`define FLASH_OPTION_BYTE_DEFINES_SVH
`define FLASH_OPTION_BYTE_ADDR_W          4
`define FLASH_OPTION_BYTE_OFS_CTRL        4'h0
`define FLASH_OPTION_BYTE_OFS_PROT        4'h1
`define FLASH_OPTION_BYTE_OFS_OPTION      4'h2
`define FLASH_OPTION_BYTE_OFS_RSV1        4'h3
`define FLASH_OPTION_BYTE_OFS_STATUS      4'h4
`define FLASH_OPTION_BYTE_OFS_PSIZE_LO    4'h5
`define FLASH_OPTION_BYTE_OFS_PSIZE_HI    4'h6
`define FLASH_OPTION_BYTE_NV_GADDR        24'hfffe0e
`define FLASH_OPTION_BYTE_PROT_STEP_SHIFT 5
`define FLASH_OPTION_BYTE_PROT_RST        5'h00
`define FLASH_OPTION_BYTE_OPTION_ALL_ONES 8'hff
`define FLASH_OPTION_BYTE_OPTION_RST      8'h00
`define FLASH_OPTION_BYTE_RSV1_VALUE      8'h00
`define FLASH_OPTION_BYTE_STAT_LOADED_BIT 0
`define FLASH_OPTION_BYTE_STAT_DBERR_BIT  1
`define FLASH_OPTION_BYTE_STAT_SPECIAL_BIT 2
`endif

// ### common/flash_option_byte_pkg.sv
// Purpose: Types shared by the option block
// Assumes: Constants come from flash_option_byte_defines.svh
// Notes:   Register request travels as one struct
`include "flash_option_byte_defines.svh"
package flash_option_byte_pkg;
  typedef struct packed {
    logic [`FLASH_OPTION_BYTE_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic                    wr;
    logic                    rd;
  } flash_option_byte_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       dbl_err;
    logic       valid;
  } flash_option_byte_nvm_rsp_t;

  typedef enum logic [1:0] {
    FLASH_OPTION_BYTE_ST_IDLE,
    FLASH_OPTION_BYTE_ST_FETCH,
    FLASH_OPTION_BYTE_ST_DONE
  } flash_option_byte_state_t;
endpackage : flash_option_byte_pkg

// ### core/flash_option_byte_flash_option.sv
// Purpose: Flash option byte, reserved register and EEPROM protection sizing
// Assumes: Reset-time fetch of the configuration byte via a simple read port
// Notes:   Read data appears the cycle after the read strobe
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "flash_option_byte_defines.svh"
module flash_option_byte_flash_option (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  // Mode
  input  wire logic                  special_mode_in,
  // Register port
  input  wire flash_option_byte_pkg::flash_option_byte_req_t   reg_req_in,
  output logic [7:0]                 reg_rdata_out,
  // Nonvolatile fetch port
  output logic                       nvm_rd_out,
  output logic [23:0]                nvm_addr_out,
  input  wire flash_option_byte_pkg::flash_option_byte_nvm_rsp_t nvm_rsp_in,
  // Block outputs
  output logic                       load_done_out,
  output logic [7:0]                 nonvolatile_option_bits_out,
  output logic [10:0]                protect_bytes_out
);
  import flash_option_byte_pkg::*;

  // Sequencer state
  flash_option_byte_state_t state;

  // Software visible storage
  logic [4:0]  eeprom_protect_size;
  logic [7:0]  flash_option_byte;
  logic        dbl_err_seen;

  // Read path
  logic [7:0]  next_rdata;

  // Shared decodes
  logic [10:0] prot_value;
  logic        fetch_hit;
  logic        load_done;
  logic        option_wr;
  logic        protect_wr;

  // Protected size in bytes.
  // A field of zero already covers the first 32-byte step, so the
  // all-ones field reaches exactly 1 KB; 11 bits hold that top value.
  function automatic logic [10:0] prot_bytes(input logic [4:0] sz);
    prot_bytes = ({6'h00, sz} + 11'h001) << `FLASH_OPTION_BYTE_PROT_STEP_SHIFT;
  endfunction : prot_bytes

  // Write decode shared by every register that software may change
  function automatic logic reg_write_hit(input flash_option_byte_req_t                req,
                                         input logic [`FLASH_OPTION_BYTE_ADDR_W-1:0] ofs);
    reg_write_hit = req.wr && (req.addr == ofs);
  endfunction : reg_write_hit

  // Conditions for the processes below; load_done, fetch_hit and prot_value are used by more than one
  assign load_done  = (state == FLASH_OPTION_BYTE_ST_DONE);
  assign fetch_hit  = (state == FLASH_OPTION_BYTE_ST_FETCH) && nvm_rsp_in.valid;
  // Option writes wait for the fetch, or the fetch would undo them
  assign option_wr  = load_done && special_mode_in &&
                      reg_write_hit(reg_req_in, `FLASH_OPTION_BYTE_OFS_OPTION);
  assign protect_wr = reg_write_hit(reg_req_in, `FLASH_OPTION_BYTE_OFS_PROT);
  assign prot_value = prot_bytes(eeprom_protect_size);

  // Reset-time fetch sequencer.
  // One fetch per reset only, so a later software write is never
  // overwritten by a stale configuration byte.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= FLASH_OPTION_BYTE_ST_IDLE;
    end else begin
      unique case (state)
        FLASH_OPTION_BYTE_ST_IDLE: begin
          // Leave idle at once; the request goes out on this edge
          state <= FLASH_OPTION_BYTE_ST_FETCH;
        end
        FLASH_OPTION_BYTE_ST_FETCH: begin
          if (nvm_rsp_in.valid) begin
            state <= FLASH_OPTION_BYTE_ST_DONE;
          end
        end
        FLASH_OPTION_BYTE_ST_DONE: begin
          // Parked until the next reset
          state <= FLASH_OPTION_BYTE_ST_DONE;
        end
        default: begin
          // Unused code: restart the fetch rather than hang
          state <= FLASH_OPTION_BYTE_ST_IDLE;
        end
      endcase
    end
  end

  // Fetch request held until the answer arrives.
  // Cleared on the edge that samples valid, so it is low from the next cycle and no second answer is asked for.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      nvm_rd_out <= 1'b0;
    end else begin
      nvm_rd_out <= !load_done && !nvm_rsp_in.valid;
    end
  end

  // Fetch address is fixed; registered so the output comes from a flop
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      nvm_addr_out <= 24'h000000;
    end else begin
      nvm_addr_out <= `FLASH_OPTION_BYTE_NV_GADDR;
    end
  end

  // Option byte: fetched once, then software may write in special mode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flash_option_byte <= `FLASH_OPTION_BYTE_OPTION_RST;
    end else if (fetch_hit) begin
      if (nvm_rsp_in.dbl_err) begin
        // Double fault forces all ones so options fail safe
        flash_option_byte <= `FLASH_OPTION_BYTE_OPTION_ALL_ONES;
      end else begin
        flash_option_byte <= nvm_rsp_in.data;
      end
    end else if (option_wr) begin
      flash_option_byte <= reg_req_in.wdata;
    end
  end

  // Fault flag, kept apart so software can tell a real ff from a fault
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dbl_err_seen <= 1'b0;
    end else if (fetch_hit) begin
      dbl_err_seen <= nvm_rsp_in.dbl_err;
    end
  end

  // Protection size field, writable any time
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      eeprom_protect_size <= `FLASH_OPTION_BYTE_PROT_RST;
    end else if (protect_wr) begin
      eeprom_protect_size <= reg_req_in.wdata[4:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_req_in.addr)
      `FLASH_OPTION_BYTE_OFS_PROT: begin
        next_rdata = {3'h0, eeprom_protect_size};
      end
      `FLASH_OPTION_BYTE_OFS_OPTION: begin
        // Hidden until fetch ends so software never sees a half-loaded value
        next_rdata = load_done ? flash_option_byte : `FLASH_OPTION_BYTE_OPTION_RST;
      end
      `FLASH_OPTION_BYTE_OFS_RSV1: begin
        // Writes never reach this register, so it holds no storage
        next_rdata = `FLASH_OPTION_BYTE_RSV1_VALUE;
      end
      `FLASH_OPTION_BYTE_OFS_STATUS: begin
        next_rdata[`FLASH_OPTION_BYTE_STAT_LOADED_BIT]  = load_done;
        next_rdata[`FLASH_OPTION_BYTE_STAT_DBERR_BIT]   = dbl_err_seen;
        next_rdata[`FLASH_OPTION_BYTE_STAT_SPECIAL_BIT] = special_mode_in;
      end
      `FLASH_OPTION_BYTE_OFS_PSIZE_LO: begin
        next_rdata = prot_value[7:0];
      end
      `FLASH_OPTION_BYTE_OFS_PSIZE_HI: begin
        next_rdata = {5'h00, prot_value[10:8]};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= next_rdata;
    end else begin
      // Zero between reads keeps stale data off the bus
      reg_rdata_out <= 8'h00;
    end
  end

  // Load status output
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      load_done_out <= 1'b0;
    end else begin
      load_done_out <= load_done;
    end
  end

  // Option bits output; reset value shown until the fetch is over
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      nonvolatile_option_bits_out <= `FLASH_OPTION_BYTE_OPTION_RST;
    end else if (load_done) begin
      nonvolatile_option_bits_out <= flash_option_byte;
    end else begin
      nonvolatile_option_bits_out <= `FLASH_OPTION_BYTE_OPTION_RST;
    end
  end

  // Protected byte count output
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      protect_bytes_out <= 11'h000;
    end else begin
      protect_bytes_out <= prot_value;
    end
  end
endmodule : flash_option_byte_flash_option
`default_nettype wire

// ### tb/flash_option_byte_flash_option_asserts.sv
// Purpose: Port checks for the option block
// Assumes: Top ports only
// Notes:   Bound after the module
`timescale 1ns/1ns
`default_nettype none
module flash_option_byte_chk
  import flash_option_byte_pkg::*;
(
  // Watched ports
  input wire logic          clk_sys_in, rst_in, special_mode_in, nvm_rd_out, load_done_out,
  input wire flash_option_byte_req_t     reg_req_in,
  input wire flash_option_byte_nvm_rsp_t nvm_rsp_in,
  input wire logic [7:0]    reg_rdata_out, nonvolatile_option_bits_out,
  input wire logic [23:0]   nvm_addr_out,
  input wire logic [10:0]   protect_bytes_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Decoded strobes
  wire wr2 = reg_req_in.wr && reg_req_in.addr == 4'h2;
  wire ok = nvm_rsp_in.valid && nvm_rd_out;
  step_size_a: assert property (protect_bytes_out[4:0] == 5'h00) else $error("size step");
  size_max_a: assert property (protect_bytes_out <= 11'h400) else $error("size max");
  opt_read_a: assert property (reg_req_in.rd && reg_req_in.addr == 4'h2 |=>
    reg_rdata_out == nonvolatile_option_bits_out) else $error("option read");
  opt_guard_a: assert property (wr2 && !special_mode_in && load_done_out |->
    ##2 $stable(nonvolatile_option_bits_out)) else $error("option guard");
  fetch_addr_a: assert property (nvm_rd_out |-> nvm_addr_out == 24'hfffe0e) else $error("addr");
  fetch_load_a: assert property (ok && !nvm_rsp_in.dbl_err |-> ##2 load_done_out &&
    nonvolatile_option_bits_out == $past(nvm_rsp_in.data, 2)) else $error("load");
  dbl_err_a: assert property (ok && nvm_rsp_in.dbl_err |-> ##2
    nonvolatile_option_bits_out == 8'hff) else $error("fault load");
  opt_write_a: assert property (wr2 && special_mode_in && load_done_out |->
    ##2 nonvolatile_option_bits_out == $past(reg_req_in.wdata, 2)) else $error("option write");
  rsv_zero_a: assert property (reg_req_in.rd && reg_req_in.addr == 4'h3 |=>
    reg_rdata_out == 8'h00) else $error("reserved");
  hold_zero_a: assert property (!load_done_out |-> nonvolatile_option_bits_out == 8'h00)
    else $error("early option");
  cover property (ok && nvm_rsp_in.dbl_err);
  cover property (wr2 && special_mode_in);
  cover property (reg_req_in.rd && reg_req_in.addr == 4'h3);
endmodule : flash_option_byte_chk
bind flash_option_byte_flash_option flash_option_byte_chk flash_option_byte_chk_i (
  .clk_sys_in                  (clk_sys_in),
  .rst_in                      (rst_in),
  .special_mode_in             (special_mode_in),
  .nvm_rd_out                  (nvm_rd_out),
  .load_done_out               (load_done_out),
  .reg_req_in                  (reg_req_in),
  .nvm_rsp_in                  (nvm_rsp_in),
  .reg_rdata_out               (reg_rdata_out),
  .nonvolatile_option_bits_out (nonvolatile_option_bits_out),
  .nvm_addr_out                (nvm_addr_out),
  .protect_bytes_out           (protect_bytes_out)
);
`default_nettype wire

// ### tb/test_flash_option_and_eeprom_protect.sv
// Purpose: Bench for the option block
// Assumes: Plain register port, one fetch per reset
// Notes:   Second reset loads with a fault
`timescale 1ns/1ns
`default_nettype none
module test_flash_option_and_eeprom_protect;
  import flash_option_byte_pkg::*;
  logic          clk_sys_in = 0, rst_in = 1, special_mode_in = 0, nvm_rd_out, load_done_out;
  flash_option_byte_req_t     reg_req_in = '0;
  flash_option_byte_nvm_rsp_t nvm_rsp_in = '0;
  logic [7:0]    reg_rdata_out, nonvolatile_option_bits_out;
  logic [23:0]   nvm_addr_out;
  logic [10:0]   protect_bytes_out;
  int            err_count = 0, checks = 0, cyc = 0;
  flash_option_byte_flash_option flash_option_byte_flash_option_i (
    .clk_sys_in                  (clk_sys_in),
    .rst_in                      (rst_in),
    .special_mode_in             (special_mode_in),
    .reg_req_in                  (reg_req_in),
    .reg_rdata_out               (reg_rdata_out),
    .nvm_rd_out                  (nvm_rd_out),
    .nvm_addr_out                (nvm_addr_out),
    .nvm_rsp_in                  (nvm_rsp_in),
    .load_done_out               (load_done_out),
    .nonvolatile_option_bits_out (nonvolatile_option_bits_out),
    .protect_bytes_out           (protect_bytes_out)
  );
  // Clock and hang guard
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc > 3000) begin err_count++; summarize(); end
  end
  task automatic cmp(input logic [23:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) reg_req_in <= {a, d, 2'b10};
    @(posedge clk_sys_in) reg_req_in <= '0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_in) reg_req_in <= {a, 8'h00, 2'b01};
    @(posedge clk_sys_in) reg_req_in <= '0;
    #1 cmp(24'(reg_rdata_out), 24'(e));
  endtask : rd
  task automatic boot(input logic [7:0] d, input logic e);
    @(posedge clk_sys_in) rst_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(4'h2, 8'h00);
    for (int i = 0; i < 20 && !nvm_rd_out; i++) @(posedge clk_sys_in);
    cmp(nvm_addr_out, 24'hfffe0e);
    @(posedge clk_sys_in) nvm_rsp_in <= {d, e, 1'b1};
    @(posedge clk_sys_in) nvm_rsp_in <= '0;
    repeat (2) @(posedge clk_sys_in);
    #1 cmp({23'h0, load_done_out}, 24'h1);
    cmp(24'(nonvolatile_option_bits_out), 24'(e ? 8'hff : d));
    cmp({23'h0, nvm_rd_out}, 24'h0);
  endtask : boot
  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    boot(8'ha5, 1'b0);
    rd(4'h2, 8'ha5);
    wr(4'h2, 8'h3c); rd(4'h2, 8'ha5);
    @(posedge clk_sys_in) special_mode_in <= 1'b1;
    wr(4'h2, 8'h3c); rd(4'h2, 8'h3c);
    rd(4'h4, 8'h05);
    wr(4'h3, 8'hff); rd(4'h3, 8'h00);
    rd(4'h7, 8'h00);
    for (int s = 0; s < 32; s = s * 2 + 1) begin
      wr(4'h1, 8'(s)); rd(4'h5, 8'((s + 1) * 32));
      rd(4'h6, 8'((s + 1) * 32 >> 8));
      cmp(24'(protect_bytes_out), 24'((s + 1) * 32));
    end
    @(posedge clk_sys_in) special_mode_in <= 1'b0;
    boot(8'h12, 1'b1); rd(4'h2, 8'hff);
    rd(4'h4, 8'h03);
    cmp(24'(protect_bytes_out), 24'h000020);
    summarize();
  end
endmodule : test_flash_option_and_eeprom_protect
`default_nettype wire
